// [design/stcs_pkg.sv]
// Package for the transmit channel status register bank.
// Assumes a byte-wide register port addressed by 7-bit register index.
// What this block does
// [RULE_01] Source number field, reset zero, into status
// [RULE_02] Channel number codes drive status bits 21:20/23:22
// [RULE_03] Indicated sample rate, reset 0001, into status
// [RULE_04] Clock accuracy field, reset 11, three levels
// [RULE_05] Data source bit selects receiver or audio interface
// [RULE_06] Status source selects received or programmed status
// [RULE_07] Status source ignored when data source receiver
// [RULE_08] Max word length flag: 20 or 24 bits
// [RULE_09] Word length code, reset 101, decoded per max flag
// [RULE_10] Original sample rate field, reset zero, into status
package stcs_pkg;
	localparam logic [6:0] STCS_ADDR_SRC_CHAN = 7'h14;
	localparam logic [6:0] STCS_ADDR_INDICATED_SAMPLE_RATE_SEL = 7'h15;
	localparam logic [6:0] STCS_ADDR_WL_ORIG = 7'h16;
	localparam logic [7:0] STCS_RST_SRC_CHAN = 8'h00;
	localparam logic [7:0] STCS_RST_INDICATED_SAMPLE_RATE_SEL = 8'h71;
	localparam logic [7:0] STCS_RST_WL_ORIG = 8'h0B;
	localparam int STCS_SOURCE_NUMBER_LSB = 0;
	localparam int STCS_CH1_LSB = 4;
	localparam int STCS_CH2_LSB = 6;
	localparam int STCS_RATE_LSB = 0;
	localparam int STCS_ACC_LSB = 4;
	localparam int STCS_TRANSMIT_DATA_SOURCE_BIT = 6;
	localparam int STCS_STSRC_BIT = 7;
	localparam int STCS_MAX_WORD_LENGTH_FLAG_BIT = 0;
	localparam int STCS_WL_LSB = 1;
	localparam int STCS_ORIG_LSB = 4;
	// Status block bit positions for the fields (consumer layout)
	localparam int STCS_CS_SRC_LSB = 16;
	localparam int STCS_CS_CH1_LSB = 20;
	localparam int STCS_CS_CH2_LSB = 22;
	localparam int STCS_CS_RATE_LSB = 24;
	localparam int STCS_CS_ACC_LSB = 28;
	localparam int STCS_CS_MAX_WORD_LENGTH_FLAG_BIT = 32;
	localparam int STCS_CS_WL_LSB = 33;
	localparam int STCS_CS_ORIG_LSB = 36;
	localparam int STCS_CS_WIDTH = 40;
endpackage

// [design/stcs_wl_decode.sv]
// Word length decoder for the transmit status word length fields.
// Pure combinational; result is zero for not indicated or reserved codes.
`timescale 1ns/1ps
module stcs_wl_decode
	import stcs_pkg::*;
(
	input wire logic max_word_length_flag, // 1 = 24-bit maximum
	input wire logic [2:0] transmit_word_length, // Word length code
	output logic [4:0] word_length_bits, // Decoded length, 0 if none
	output logic word_length_reserved // Code is reserved
);
	always_comb begin
		word_length_reserved = 1'b0;
		case (transmit_word_length) // RULE_09
			3'h1: word_length_bits = 5'h10;
			3'h2: word_length_bits = 5'h12;
			3'h4: word_length_bits = 5'h13;
			3'h5: word_length_bits = 5'h14;
			3'h6: word_length_bits = 5'h11;
			3'h0: word_length_bits = 5'h00;
			default: begin
				word_length_bits = 5'h00;
				word_length_reserved = 1'b1;
			end
		endcase
		if (max_word_length_flag && word_length_bits != 5'h00) begin // RULE_08
			word_length_bits = word_length_bits + 5'h04;
		end
	end
endmodule

// [design/stcs_regs.sv]
// Transmit channel status register bank and status source selection.
// Assumes a synchronous byte-wide register port from the control interface.
`timescale 1ns/1ps
module stcs_regs
	import stcs_pkg::*;
(
	input wire logic clk_sys, // System clock, 25 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic clk_en, // Freezes all state when low
	input wire logic reg_wr, // Register write strobe
	input wire logic [6:0] reg_addr, // Register index
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data of addressed register
	output logic reg_hit, // Address matches this bank
	input wire logic [STCS_CS_WIDTH-1:0] rx_status, // Received status bits
	output logic [STCS_CS_WIDTH-1:0] tx_status_r, // Status sent by transmitter
	output logic tx_from_audio_if, // 1: audio interface, master clock
	output logic tx_status_local, // 1: programmed status sent
	output logic [1:0] subframe_one_chan, // 0 none, 1 left, 2 right
	output logic [1:0] subframe_two_chan, // 0 none, 1 left, 2 right
	output logic [4:0] word_length_bits_r, // Decoded word length, 0 if none
	output logic word_length_reserved_r // Programmed code is reserved
);
	// Three byte registers live in one array picked by a small index, so the
	// write path, the read path and the reset share one address decode.
	localparam int NUM_REGS = 3;
	localparam int IDX_W = 2;
	localparam logic [IDX_W-1:0] IDX_SRC_CHAN = 2'h0;
	localparam logic [IDX_W-1:0] IDX_INDICATED_SAMPLE_RATE_SEL = 2'h1;
	localparam logic [IDX_W-1:0] IDX_WL_ORIG = 2'h2;
	// Field widths are fixed by the status block layout
	localparam int W_SOURCE_NUMBER = 4;
	localparam int W_CHAN = 2;
	localparam int W_RATE = 4;
	localparam int W_ACC = 2;
	localparam int W_WL = 3;
	localparam int W_ORIG = 4;

	// Register storage and write decode
	logic [7:0] regs_r [NUM_REGS];
	logic wr_go;
	logic [IDX_W-1:0] wr_idx;
	logic [NUM_REGS-1:0] wr_sel;

	// Read decode
	logic rd_mapped;
	logic [IDX_W-1:0] rd_idx;
	logic [7:0] rd_byte;

	// Named field views of the registers
	logic [3:0] source_number;
	logic [1:0] subframe_one_channel_number;
	logic [1:0] subframe_two_channel_number;
	logic [3:0] indicated_sample_rate;
	logic [1:0] clock_accuracy_level;
	logic transmit_data_source;
	logic channel_status_source;
	logic max_word_length_flag;
	logic [2:0] transmit_word_length;
	logic [3:0] original_sample_rate;

	// Programmed status, its selection and the decoded length
	logic [STCS_CS_WIDTH-1:0] local_status;
	logic [STCS_CS_WIDTH-1:0] tx_status_nxt;
	logic [4:0] wl_bits;
	logic wl_res;
	logic [4:0] word_length_bits_nxt;
	logic word_length_reserved_nxt;

	function automatic logic addr_mapped(input logic [6:0] a);
		case (a)
			STCS_ADDR_SRC_CHAN: begin
				addr_mapped = 1'b1;
			end
			STCS_ADDR_INDICATED_SAMPLE_RATE_SEL: begin
				addr_mapped = 1'b1;
			end
			STCS_ADDR_WL_ORIG: begin
				addr_mapped = 1'b1;
			end
			default: begin
				addr_mapped = 1'b0;
			end
		endcase
	endfunction

	// Unmapped addresses fold onto index 0; every caller gates with addr_mapped
	function automatic logic [IDX_W-1:0] addr_index(input logic [6:0] a);
		case (a)
			STCS_ADDR_SRC_CHAN: begin
				addr_index = IDX_SRC_CHAN;
			end
			STCS_ADDR_INDICATED_SAMPLE_RATE_SEL: begin
				addr_index = IDX_INDICATED_SAMPLE_RATE_SEL;
			end
			STCS_ADDR_WL_ORIG: begin
				addr_index = IDX_WL_ORIG;
			end
			default: begin
				addr_index = IDX_SRC_CHAN;
			end
		endcase
	endfunction

	function automatic logic [7:0] reset_value(input int i);
		case (i)
			0: begin
				reset_value = STCS_RST_SRC_CHAN; // RULE_01
			end
			1: begin
				reset_value = STCS_RST_INDICATED_SAMPLE_RATE_SEL; // RULE_03
			end
			2: begin
				reset_value = STCS_RST_WL_ORIG; // RULE_09
			end
			default: begin
				reset_value = 8'h00;
			end
		endcase
	endfunction

	// Codes 00 and 11 both mean no channel number; 11 is folded onto 00 so
	// that downstream logic sees a single code for it
	function automatic logic [1:0] chan_code(input logic [1:0] c);
		case (c)
			2'h1: begin
				chan_code = 2'h1;
			end
			2'h2: begin
				chan_code = 2'h2;
			end
			2'h3: begin
				chan_code = 2'h0;
			end
			default: begin
				chan_code = 2'h0;
			end
		endcase
	endfunction

	// Status bits that the programmed registers own; all others pass through
	function automatic logic cs_owned(input int i);
		cs_owned = 1'b0;
		if (i >= STCS_CS_SRC_LSB && i < STCS_CS_SRC_LSB + W_SOURCE_NUMBER) begin
			cs_owned = 1'b1;
		end
		if (i >= STCS_CS_CH1_LSB && i < STCS_CS_CH1_LSB + W_CHAN) begin
			cs_owned = 1'b1;
		end
		if (i >= STCS_CS_CH2_LSB && i < STCS_CS_CH2_LSB + W_CHAN) begin
			cs_owned = 1'b1;
		end
		if (i >= STCS_CS_RATE_LSB && i < STCS_CS_RATE_LSB + W_RATE) begin
			cs_owned = 1'b1;
		end
		if (i >= STCS_CS_ACC_LSB && i < STCS_CS_ACC_LSB + W_ACC) begin
			cs_owned = 1'b1;
		end
		if (i == STCS_CS_MAX_WORD_LENGTH_FLAG_BIT) begin
			cs_owned = 1'b1;
		end
		if (i >= STCS_CS_WL_LSB && i < STCS_CS_WL_LSB + W_WL) begin
			cs_owned = 1'b1;
		end
		if (i >= STCS_CS_ORIG_LSB && i < STCS_CS_ORIG_LSB + W_ORIG) begin
			cs_owned = 1'b1;
		end
	endfunction

	// A write lands only on an enabled edge at a mapped address
	assign wr_go = clk_en && reg_wr && addr_mapped(reg_addr);
	assign wr_idx = addr_index(reg_addr);

	// One flip-flop process per register; clk_en gating already sits in wr_sel
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			assign wr_sel[gi] = wr_go && (wr_idx == IDX_W'(gi));

			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					regs_r[gi] <= reset_value(gi);
				end else if (wr_sel[gi]) begin
					regs_r[gi] <= reg_wdata;
				end
			end
		end
	endgenerate

	assign rd_mapped = addr_mapped(reg_addr);
	assign rd_idx = addr_index(reg_addr);

	// Loop compare keeps the index inside the array for every code
	always_comb begin
		rd_byte = 8'h00;
		for (int k = 0; k < NUM_REGS; k++) begin
			if (rd_idx == IDX_W'(k)) begin
				rd_byte = regs_r[k];
			end
		end
	end

	// Unmapped addresses read zero so a stray read never aliases a register
	always_comb begin
		reg_hit = rd_mapped;
		reg_rdata = 8'h00;
		if (rd_mapped) begin
			reg_rdata = rd_byte;
		end
	end

	always_comb begin
		source_number = regs_r[IDX_SRC_CHAN][STCS_SOURCE_NUMBER_LSB +: W_SOURCE_NUMBER]; // RULE_01
		subframe_one_channel_number = regs_r[IDX_SRC_CHAN][STCS_CH1_LSB +: W_CHAN]; // RULE_02
		subframe_two_channel_number = regs_r[IDX_SRC_CHAN][STCS_CH2_LSB +: W_CHAN]; // RULE_02
	end

	always_comb begin
		indicated_sample_rate = regs_r[IDX_INDICATED_SAMPLE_RATE_SEL][STCS_RATE_LSB +: W_RATE]; // RULE_03
		clock_accuracy_level = regs_r[IDX_INDICATED_SAMPLE_RATE_SEL][STCS_ACC_LSB +: W_ACC]; // RULE_04
		transmit_data_source = regs_r[IDX_INDICATED_SAMPLE_RATE_SEL][STCS_TRANSMIT_DATA_SOURCE_BIT]; // RULE_05
		channel_status_source = regs_r[IDX_INDICATED_SAMPLE_RATE_SEL][STCS_STSRC_BIT]; // RULE_06
	end

	always_comb begin
		max_word_length_flag = regs_r[IDX_WL_ORIG][STCS_MAX_WORD_LENGTH_FLAG_BIT]; // RULE_08
		transmit_word_length = regs_r[IDX_WL_ORIG][STCS_WL_LSB +: W_WL]; // RULE_09
		original_sample_rate = regs_r[IDX_WL_ORIG][STCS_ORIG_LSB +: W_ORIG]; // RULE_10
	end

	assign subframe_one_chan = chan_code(subframe_one_channel_number); // RULE_02
	assign subframe_two_chan = chan_code(subframe_two_channel_number); // RULE_02
	assign tx_from_audio_if = transmit_data_source; // RULE_05
	// Receiver-sourced data must carry its own status, so the select is masked
	assign tx_status_local = transmit_data_source & channel_status_source; // RULE_07

	// Channel fields go into the status raw; only the ports fold 11 onto 00
	always_comb begin
		local_status = '0;
		local_status[STCS_CS_SRC_LSB +: W_SOURCE_NUMBER] = source_number; // RULE_01
		local_status[STCS_CS_CH1_LSB +: W_CHAN] = subframe_one_channel_number; // RULE_02
		local_status[STCS_CS_CH2_LSB +: W_CHAN] = subframe_two_channel_number; // RULE_02
		local_status[STCS_CS_RATE_LSB +: W_RATE] = indicated_sample_rate; // RULE_03
		local_status[STCS_CS_ACC_LSB +: W_ACC] = clock_accuracy_level; // RULE_04
		local_status[STCS_CS_MAX_WORD_LENGTH_FLAG_BIT] = max_word_length_flag; // RULE_08
		local_status[STCS_CS_WL_LSB +: W_WL] = transmit_word_length; // RULE_09
		local_status[STCS_CS_ORIG_LSB +: W_ORIG] = original_sample_rate; // RULE_10
	end

	genvar gb;
	generate
		for (gb = 0; gb < STCS_CS_WIDTH; gb++) begin : g_cs
			// Unowned bits follow the received stream in either mode
			logic pick_local;
			assign pick_local = tx_status_local && cs_owned(gb); // RULE_06
			assign tx_status_nxt[gb] = pick_local ? local_status[gb] : rx_status[gb];
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_status_r <= '0;
		end else if (clk_en) begin
			tx_status_r <= tx_status_nxt; // RULE_06
		end
	end

	stcs_wl_decode u_wl (
		.max_word_length_flag(max_word_length_flag),
		.transmit_word_length(transmit_word_length),
		.word_length_bits(wl_bits),
		.word_length_reserved(wl_res)
	);

	// Decoded length is registered so it moves in step with tx_status_r
	always_comb begin
		word_length_bits_nxt = word_length_bits_r;
		word_length_reserved_nxt = word_length_reserved_r;
		if (clk_en) begin
			word_length_bits_nxt = wl_bits; // RULE_09
			word_length_reserved_nxt = wl_res; // RULE_09
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			word_length_bits_r <= 5'h00;
		end else begin
			word_length_bits_r <= word_length_bits_nxt;
		end
	end

	// Reserved flag kept apart: it is a status of the code, not a length
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			word_length_reserved_r <= 1'b0;
		end else begin
			word_length_reserved_r <= word_length_reserved_nxt;
		end
	end
endmodule

// [verif/stcs_regs_props.sv]
// Checker for the transmit channel status register bank.
// Assumes it is bound to every stcs_regs instance.
`timescale 1ns/1ps
module stcs_regs_props
	import stcs_pkg::*;
(
	input wire logic clk_sys, sys_rst, clk_en, tx_from_audio_if, tx_status_local,
	input wire logic word_length_reserved_r,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic [STCS_CS_WIDTH-1:0] rx_status, tx_status_r,
	input wire logic [1:0] subframe_one_chan, subframe_two_chan,
	input wire logic [4:0] word_length_bits_r
);
	wire a4 = reg_addr == STCS_ADDR_SRC_CHAN;
	wire a5 = reg_addr == STCS_ADDR_INDICATED_SAMPLE_RATE_SEL;
	wire a6 = reg_addr == STCS_ADDR_WL_ORIG;
	wire loc = clk_en && tx_status_local;
	// Register contents are only visible through the read port, so checks key on the address
	function automatic logic [5:0] wl(input logic [3:0] v);
		case (v[3:1])
			3'h0: wl = 6'h00;
			3'h1: wl = v[0] ? 6'h14 : 6'h10;
			3'h2: wl = v[0] ? 6'h16 : 6'h12;
			3'h4: wl = v[0] ? 6'h17 : 6'h13;
			3'h5: wl = v[0] ? 6'h18 : 6'h14;
			3'h6: wl = v[0] ? 6'h15 : 6'h11;
			default: wl = 6'h20;
		endcase
	endfunction
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_RST_SEL: assert property (disable iff (1'b0) sys_rst |=> tx_from_audio_if && !tx_status_local)
		else $error("select bits wrong after reset");
	AST_RST_WL: assert property (disable iff (1'b0) sys_rst ##1 !sys_rst && clk_en |=> word_length_bits_r == 5'h18)
		else $error("word length wrong after reset");
	AST_SRC_SEL: assert property (a5 |-> tx_from_audio_if == reg_rdata[6] && tx_status_local == &reg_rdata[7:6])
		else $error("status source select wrong");
	AST_PASS: assert property (clk_en && !tx_status_local |=> tx_status_r == $past(rx_status))
		else $error("received status not passed through");
	AST_LOC14: assert property (loc && a4 |=> tx_status_r[23:0] == {$past(reg_rdata), $past(rx_status[15:0])})
		else $error("source or channel fields wrong");
	AST_LOC15: assert property (loc && a5 |=> tx_status_r[31:24] == {$past(rx_status[31:30]), $past(reg_rdata[5:0])})
		else $error("rate or accuracy fields wrong");
	AST_LOC16: assert property (loc && a6 |=> tx_status_r[39:32] == $past(reg_rdata))
		else $error("word length or original rate wrong");
	AST_CHAN: assert property (a4 |-> subframe_one_chan == (&reg_rdata[5:4] ? 2'h0 : reg_rdata[5:4]))
		else $error("channel number mapping wrong");
	AST_CHAN2: assert property (a4 |-> subframe_two_chan == (&reg_rdata[7:6] ? 2'h0 : reg_rdata[7:6]))
		else $error("second channel number mapping wrong");
	AST_WL: assert property (clk_en && a6 |=> {word_length_reserved_r, word_length_bits_r} == wl($past(reg_rdata[3:0])))
		else $error("word length decode wrong");
	cover property (loc && a6);
	cover property (!clk_en && a4);
	cover property (a5 && reg_rdata[7:6] == 2'h2);
	cover property (a4 && subframe_two_chan == 2'h2);
endmodule
bind stcs_regs stcs_regs_props u_props (.*);

// [verif/testbench.sv]
// Self-checking bench for the transmit channel status register bank.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/1ps
module testbench;
	import stcs_pkg::*;
	logic clk_sys = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_hit, tx_from_audio_if, tx_status_local;
	logic word_length_reserved_r;
	logic [6:0] reg_addr = 7'h14;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [39:0] rx_status = 40'hA55A3CC3F0, tx_status_r;
	logic [1:0] subframe_one_chan, subframe_two_chan;
	logic [4:0] word_length_bits_r;
	int mismatches = 0, comparisons = 0;
	// Address, write data, expected read back
	logic [23:0] rows [7] = '{24'h145E5E, 24'h15C3C3, 24'h16A9A9, 24'h17FF00, 24'h160606, 24'h158F8F, 24'h14F0F0};
	stcs_regs DUT (.*);
	initial forever #20 clk_sys = ~clk_sys;
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge clk_sys);
		#1 reg_wr = 0;
	endtask
	task automatic report_and_stop;
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		#1 sys_rst = 0;
		chk("reset 0x14", 8'h00, reg_rdata);
		reg_addr = 7'h15;
		#1 chk("reset 0x15", 8'h71, reg_rdata);
		reg_addr = 7'h16;
		#1 chk("reset 0x16", 8'h0B, reg_rdata);
		foreach (rows[i]) begin
			wr(rows[i][22:16], rows[i][15:8]);
			chk("reg_rdata", rows[i][7:0], reg_rdata);
			chk("reg_hit", rows[i][23:16] != 8'h17, reg_hit);
		end
		// Data source is receiver here, so the local status request must be ignored
		@(posedge clk_sys);
		#1 chk("tx_status_r", rx_status, tx_status_r);
		chk("subframe_one_chan", 2'h0, subframe_one_chan);
		chk("word length", 6'h20, {word_length_reserved_r, word_length_bits_r});
		wr(7'h15, 8'hC2);
		@(posedge clk_sys);
		#1 chk("tx_status_r", {8'h06, rx_status[31:30], 6'h02, 8'hF0, rx_status[15:0]}, tx_status_r);
		clk_en = 0;
		wr(7'h14, 8'h5A);
		clk_en = 1;
		chk("frozen 0x14", 8'hF0, reg_rdata);
		wr(7'h14, 8'h9A);
		chk("subframe_one_chan", 2'h1, subframe_one_chan);
		chk("subframe_two_chan", 2'h2, subframe_two_chan);
		wr(7'h16, 8'h0A);
		@(posedge clk_sys);
		#1 chk("word length", 6'h14, {word_length_reserved_r, word_length_bits_r});
		// Reset in mid-run must restore register 0x16 and clear the status
		@(posedge clk_sys);
		#1 sys_rst = 1;
		repeat (2) @(posedge clk_sys);
		#1 sys_rst = 0;
		chk("tx_status_r after reset", 40'h0, tx_status_r);
		chk("reset 0x16 again", 8'h0B, reg_rdata);
		@(posedge clk_sys);
		#1 chk("word length after reset", 6'h18, {word_length_reserved_r, word_length_bits_r});
		report_and_stop();
	end
endmodule
